// *** logic/dual_tc_regs.vh ***
`ifndef DUAL_TC_REGS_VH
`define DUAL_TC_REGS_VH
// clock rate and timing
`define CLK_KHZ        10000
`define GATE_MS        839
`define GATE_CYCLES    (`GATE_MS * `CLK_KHZ)
`define MIN_PULSE_NS   200
`define MIN_PULSE_CYC  ((`MIN_PULSE_NS * `CLK_KHZ + 999999) / 1000000)
// register indices, byte address is index times four
`define REG_CTRLA      3'h0
`define REG_CTRLB      3'h1
`define REG_LOAD_LO    3'h2
`define REG_LOAD_HI    3'h3
`define REG_LATCH_LO   3'h4
`define REG_LATCH_HI   3'h5
`define REG_STATUS     3'h6
`define REG_GLOBAL     5'h10
// control a fields
`define CA_MODE_MSB    3
`define CA_EXT_BIT     4
`define CA_EDGE_LSB    5
// control b fields
`define CB_RATE_MSB    2
`define CB_INSEL_LSB   3
// global and status bits
`define GL_EDGELOG_BIT 0
`define ST_CAPT_BIT    0
`define ST_OUT_BIT     1
`define ST_BUSY_BIT    2
// reset values
`define CTRL_RST       8'h00
`define LOAD_RST       16'h0000
// edge selections
`define EDGE_RISE      2'h0
`define EDGE_FALL      2'h1
`define EDGE_BOTH      2'h2
// function codes
`define M_IDLE         4'h0
`define M_ONTIME       4'h1
`define M_PERIOD       4'h2
`define M_PCOUNT_IN    4'h3
`define M_TOTAL        4'h4
`define M_QUAD         4'h5
`define M_FREQ         4'h6
`define M_ONESHOT      4'h7
`define M_PCOUNT_OUT   4'h8
`define M_PWIDTH       4'h9
`define M_EDGEDIV      4'ha
`define M_TRIGCNT      4'hb
// quadrature limits
`define QUAD_MAX       16'h3fff
`define QUAD_MIN       16'hc001
`endif

// *** logic/dual_timer_counter_unit.v ***
// Contract
// - two independent sixteen-bit timer/counter units
// - unit zero input lines 4-7, output line 0
// - unit one input line 4, with line 5 as its quadrature partner, output line 1
// - load register, counter, readable latch per unit
// - load and latch moved one byte per access
// - clock from pin edges or prescaled clock
// - each unit keeps its own rate, except while logging, when both use unit zero's
// - rising, falling or both edges selectable
// - unit events raise an event request
// - transition logging uses both units, line 4
// - high time and period 0.2us to 1.678s
// - edge count to 65535, gated or total
// - quadrature count within plus/minus 16383
// - square wave 0.3 Hz to 2.5 MHz
// - single pulse 0.2us to 1.678s
// - pulse train duty from 0 to 100 percent
// - output is input edge rate over twice the divisor
// - output pulse ended by counted input edges
`timescale 1ns/10ps
`include "dual_tc_regs.vh"
`default_nettype none

module tc_channel #(
  parameter GATE_CYCLES = `GATE_CYCLES
) (
  input  wire        core_clk,  // system clock
  input  wire        sys_rst,   // sync reset
  input  wire [3:0]  mode,      // function code
  input  wire        src_ext,   // count pin edges
  input  wire [1:0]  edge_sel,  // edge sensitivity
  input  wire [2:0]  rate,      // prescale select
  input  wire        sig,       // selected input
  input  wire        sig_b,     // quadrature partner
  input  wire [15:0] load,      // committed load value
  input  wire        load_stb,  // load just committed
  output reg  [15:0] latch_r,   // captured value
  output reg         out_r,     // output level
  output reg         oe_r,      // output drive enable
  output reg         done_r,    // event pulse
  output reg         busy_r     // output sequence running
);
  reg  [7:0]  pre_r;
  reg         sig_d_r;
  reg         sigb_d_r;
  reg  [15:0] cnt_r;
  reg  [15:0] pulses_r;
  reg  [23:0] gate_r;
  reg  [7:0]  phase_r;
  wire [7:0]  pre_mask;
  wire        tick;
  wire        rise;
  wire        fall;
  wire        edge_hit;
  wire        step;
  wire        quad_move;
  wire        quad_up;
  wire        out_mode;

  // private prescaler, divide by two up to 256
  assign pre_mask = (8'h02 << rate) - 8'h01;
  assign tick     = (pre_r & pre_mask) == pre_mask;
  // pin edge detection
  assign rise     = sig & ~sig_d_r;
  assign fall     = ~sig & sig_d_r;
  assign edge_hit = (edge_sel == `EDGE_RISE) ? rise :
                    (edge_sel == `EDGE_FALL) ? fall :
                    (rise | fall);
  assign step     = src_ext ? edge_hit : tick;
  // gray code step and direction
  assign quad_move = (sig ^ sig_d_r) ^ (sig_b ^ sigb_d_r);
  assign quad_up   = sig_d_r ^ sig_b;
  assign out_mode  = mode >= `M_FREQ;

  // prescaler and input history
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pre_r    <= 8'h00;
      sig_d_r  <= 1'b0;
      sigb_d_r <= 1'b0;
    end else begin
      pre_r    <= pre_r + 8'h01;
      sig_d_r  <= sig;
      sigb_d_r <= sig_b;
    end
  end

  // counting engine, one case per function
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_r    <= 16'h0000;
      pulses_r <= 16'h0000;
      gate_r   <= 24'h000000;
      phase_r  <= 8'h00;
      latch_r  <= 16'h0000;
      out_r    <= 1'b0;
      oe_r     <= 1'b0;
      done_r   <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      done_r <= 1'b0;
      oe_r   <= out_mode;
      case (mode)
        `M_ONTIME: begin
          if (fall) begin
            latch_r <= cnt_r;
            done_r  <= 1'b1;
            cnt_r   <= 16'h0000;
          end else if (sig && step && cnt_r != 16'hffff) begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        `M_PERIOD: begin
          if (edge_hit) begin
            latch_r <= cnt_r;
            done_r  <= 1'b1;
            cnt_r   <= 16'h0000;
          end else if (tick && cnt_r != 16'hffff) begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        `M_PCOUNT_IN: begin
          if (gate_r >= GATE_CYCLES - 1) begin
            latch_r <= cnt_r;
            done_r  <= 1'b1;
            gate_r  <= 24'h000000;
            cnt_r   <= {15'h0000, edge_hit}; // boundary edge kept
          end else begin
            gate_r <= gate_r + 24'h000001;
            if (edge_hit && cnt_r != 16'hffff)
              cnt_r <= cnt_r + 16'h0001;
          end
        end
        `M_TOTAL: begin
          if (load_stb) begin
            cnt_r <= 16'h0000;
          end else if (edge_hit && cnt_r != 16'hffff) begin
            cnt_r  <= cnt_r + 16'h0001;
            done_r <= 1'b1;
          end
          latch_r <= cnt_r;
        end
        `M_QUAD: begin
          if (load_stb) begin
            cnt_r <= 16'h0000;
          end else if (quad_move) begin
            done_r <= 1'b1;
            if (quad_up && cnt_r != `QUAD_MAX)
              cnt_r <= cnt_r + 16'h0001;
            else if (!quad_up && cnt_r != `QUAD_MIN)
              cnt_r <= cnt_r - 16'h0001;
          end
          latch_r <= cnt_r;
        end
        `M_FREQ: begin
          busy_r <= load != 16'h0000;
          if (load == 16'h0000) begin
            out_r <= 1'b0;
            cnt_r <= 16'h0000;
          end else if (step) begin
            if (cnt_r <= 16'h0001) begin
              cnt_r <= load;
              out_r <= ~out_r;
            end else begin
              cnt_r <= cnt_r - 16'h0001;
            end
          end
        end
        `M_ONESHOT: begin
          if (load_stb && load != 16'h0000) begin
            cnt_r  <= load;
            out_r  <= 1'b1;
            busy_r <= 1'b1;
          end else if (busy_r && step) begin
            if (cnt_r <= 16'h0001) begin
              out_r  <= 1'b0;
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end else begin
              cnt_r <= cnt_r - 16'h0001;
            end
          end
        end
        `M_PCOUNT_OUT: begin
          if (load_stb) begin
            pulses_r <= load;
            busy_r   <= load != 16'h0000;
            out_r    <= 1'b0;
          end else if (busy_r && step) begin
            out_r <= ~out_r;
            if (out_r) begin
              pulses_r <= pulses_r - 16'h0001;
              if (pulses_r == 16'h0001) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
              end
            end
          end
        end
        `M_PWIDTH: begin
          busy_r <= 1'b1;
          if (step)
            phase_r <= phase_r + 8'h01;
          // duty is load/256, 256 and above holds high
          out_r <= (load[15:8] != 8'h00) ||
                   ({8'h00, phase_r} < load);
        end
        `M_EDGEDIV: begin
          busy_r <= load != 16'h0000;
          if (load == 16'h0000) begin
            out_r <= 1'b0;
          end else if (edge_hit) begin
            if (cnt_r <= 16'h0001) begin
              cnt_r <= load;
              out_r <= ~out_r;
            end else begin
              cnt_r <= cnt_r - 16'h0001;
            end
          end
        end
        `M_TRIGCNT: begin
          if (load_stb && load != 16'h0000) begin
            cnt_r  <= load;
            out_r  <= 1'b1;
            busy_r <= 1'b1;
          end else if (busy_r && edge_hit) begin
            if (cnt_r <= 16'h0001) begin
              out_r  <= 1'b0;
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end else begin
              cnt_r <= cnt_r - 16'h0001;
            end
          end
        end
        default: begin
          out_r  <= 1'b0;
          busy_r <= 1'b0;
          cnt_r  <= 16'h0000;
        end
      endcase
    end
  end
endmodule

module dual_timer_counter_unit #(
  parameter GATE_CYCLES = `GATE_CYCLES
) (
  input  wire        core_clk,          // 10 MHz clock
  input  wire        sys_rst,           // sync reset, high
  input  wire [6:0]  avs_address,       // byte address
  input  wire        avs_read,          // read request
  input  wire        avs_write,         // write request
  input  wire [3:0]  avs_byteenable,    // byte lanes
  input  wire [31:0] avs_writedata,     // write data
  output reg  [31:0] avs_readdata,      // read data
  output reg         avs_waitrequest,   // stall
  input  wire        port_line_four,    // input line 4
  input  wire        port_line_five,    // input line 5
  input  wire        port_line_six,     // input line 6
  input  wire        port_line_seven,   // input line 7
  output reg         port_line_zero_o,  // unit zero output
  output reg         port_line_zero_oe, // drive enable line 0
  output reg         port_line_one_o,   // unit one output
  output reg         port_line_one_oe,  // drive enable line 1
  output reg  [1:0]  tc_event           // per unit event pulse
);
  reg  [7:0]  ctrla_r   [0:1];
  reg  [7:0]  ctrlb_r   [0:1];
  reg  [7:0]  load_lo_r [0:1];
  reg  [15:0] load_r    [0:1];
  reg  [7:0]  hold_r    [0:1];
  reg  [1:0]  load_stb_r;
  reg  [1:0]  capt_r;
  reg         edgelog_r;
  wire [15:0] latch_w   [0:1];
  wire [1:0]  out_w;
  wire [1:0]  oe_w;
  wire [1:0]  done_w;
  wire [1:0]  busy_w;
  wire [3:0]  lines_in;
  wire [4:0]  idx;
  wire        u;
  wire [2:0]  r;
  wire        wr_go;
  wire        rd_go;

  // register of a unit: index 0-6 within an eight-word block
  function unit_hit;
    input [4:0] a;
    begin
      unit_hit = (a[4] == 1'b0) && (a[2:0] <= `REG_STATUS);
    end
  endfunction

  assign lines_in = {port_line_seven, port_line_six,
                     port_line_five, port_line_four};
  assign idx   = avs_address[6:2];
  assign u     = idx[3];
  assign r     = idx[2:0];
  assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign rd_go = avs_read & ~avs_waitrequest;

  // both units from one loop, differing in input routing and in rate source while logging
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_unit
      wire [3:0] md_w;
      wire [1:0] sel_w;
      wire [1:0] eff_w;
      wire       a_w;
      // transition logging forces both units to time line 4 phases
      assign md_w  = edgelog_r ? `M_ONTIME :
                     ctrla_r[i][`CA_MODE_MSB:0];
      assign sel_w = (i == 0 && !edgelog_r) ?
                     ctrlb_r[i][`CB_INSEL_LSB+1:`CB_INSEL_LSB] :
                     2'h0;
      assign eff_w = (md_w == `M_QUAD) ? {sel_w[1], 1'b0} :
                     sel_w;
      // unit one times low phases while logging
      assign a_w   = (i == 1 && edgelog_r) ? ~lines_in[0] :
                     lines_in[eff_w];
      tc_channel #(
        .GATE_CYCLES (GATE_CYCLES)
      ) u_ch (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .mode     (md_w),
        .src_ext  (ctrla_r[i][`CA_EXT_BIT] & ~edgelog_r),
        .edge_sel (ctrla_r[i][`CA_EDGE_LSB+1:`CA_EDGE_LSB]),
        .rate     (ctrlb_r[edgelog_r ? 0 : i][`CB_RATE_MSB:0]),
        .sig      (a_w),
        .sig_b    (lines_in[{eff_w[1], 1'b1}]),
        .load     (load_r[i]),
        .load_stb (load_stb_r[i]),
        .latch_r  (latch_w[i]),
        .out_r    (out_w[i]),
        .oe_r     (oe_w[i]),
        .done_r   (done_w[i]),
        .busy_r   (busy_w[i])
      );
    end
  endgenerate

  // avalon handshake: one wait cycle, then the transfer completes
  always @(posedge core_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      if ((avs_read | avs_write) & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= 32'h00000000;
        if (avs_read && idx == `REG_GLOBAL) begin
          avs_readdata[0] <= edgelog_r;
        end else if (avs_read && unit_hit(idx)) begin
          if (r == `REG_CTRLA)
            avs_readdata[7:0] <= ctrla_r[u];
          else if (r == `REG_CTRLB)
            avs_readdata[7:0] <= ctrlb_r[u];
          else if (r == `REG_LOAD_LO)
            avs_readdata[7:0] <= load_r[u][7:0];
          else if (r == `REG_LOAD_HI)
            avs_readdata[7:0] <= load_r[u][15:8];
          else if (r == `REG_LATCH_LO)
            avs_readdata[7:0] <= latch_w[u][7:0];
          else if (r == `REG_LATCH_HI)
            avs_readdata[7:0] <= hold_r[u];
          else
            avs_readdata[2:0] <= {busy_w[u], out_w[u], capt_r[u] | done_w[u]};
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // register writes and status read clear at completion, latch high byte freeze in the wait cycle
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ctrla_r[0]   <= `CTRL_RST;
      ctrla_r[1]   <= `CTRL_RST;
      ctrlb_r[0]   <= `CTRL_RST;
      ctrlb_r[1]   <= `CTRL_RST;
      load_lo_r[0] <= 8'h00;
      load_lo_r[1] <= 8'h00;
      load_r[0]    <= `LOAD_RST;
      load_r[1]    <= `LOAD_RST;
      hold_r[0]    <= 8'h00;
      hold_r[1]    <= 8'h00;
      load_stb_r   <= 2'b00;
      capt_r       <= 2'b00;
      edgelog_r    <= 1'b0;
    end else begin
      load_stb_r <= 2'b00;
      if (wr_go && idx == `REG_GLOBAL) begin
        edgelog_r <= avs_writedata[`GL_EDGELOG_BIT];
      end else if (wr_go && unit_hit(idx)) begin
        if (r == `REG_CTRLA)
          ctrla_r[u] <= avs_writedata[7:0];
        else if (r == `REG_CTRLB)
          ctrlb_r[u] <= avs_writedata[7:0];
        else if (r == `REG_LOAD_LO)
          load_lo_r[u] <= avs_writedata[7:0];
        else if (r == `REG_LOAD_HI) begin
          load_r[u]     <= {avs_writedata[7:0], load_lo_r[u]};
          load_stb_r[u] <= 1'b1;
        end
      end
      // high byte frozen in the cycle the low byte is sampled
      if (avs_read && avs_waitrequest && unit_hit(idx) && r == `REG_LATCH_LO)
        hold_r[u] <= latch_w[u][15:8];
      // capture flag: a new event beats a read clear
      if (rd_go && unit_hit(idx) && r == `REG_STATUS)
        capt_r[u] <= 1'b0;
      if (done_w[0])
        capt_r[0] <= 1'b1;
      if (done_w[1])
        capt_r[1] <= 1'b1;
    end
  end

  // registered pin and event outputs
  always @(posedge core_clk) begin
    if (sys_rst) begin
      port_line_zero_o  <= 1'b0;
      port_line_zero_oe <= 1'b0;
      port_line_one_o   <= 1'b0;
      port_line_one_oe  <= 1'b0;
      tc_event          <= 2'b00;
    end else begin
      port_line_zero_o  <= out_w[0];
      port_line_zero_oe <= oe_w[0] & ~edgelog_r;
      port_line_one_o   <= out_w[1];
      port_line_one_oe  <= oe_w[1] & ~edgelog_r;
      tc_event          <= done_w;
    end
  end
endmodule

`default_nettype wire

// *** dv/tc_bus_check_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module tc_bus_check #(
  parameter GATE_CYCLES = 50
) (
  input wire logic        core_clk,          // clock
  input wire logic        sys_rst,           // sync reset
  input wire logic        avs_read,          // read request
  input wire logic        avs_write,         // write request
  input wire logic [31:0] avs_readdata,      // read data
  input wire logic        avs_waitrequest,   // stall
  input wire logic        port_line_zero_o,  // unit zero output
  input wire logic        port_line_zero_oe, // line 0 enable
  input wire logic        port_line_one_o,   // unit one output
  input wire logic        port_line_one_oe,  // line 1 enable
  input wire logic [1:0]  tc_event           // event pulses
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // request seen, then a single wait cycle
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_ack;
    s_req |=> s_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer not after one wait cycle");
  property p_no_spur;
    !avs_waitrequest |->
      $past(avs_read || avs_write) && $past(avs_waitrequest);
  endproperty
  a_no_spur: assert property (p_no_spur)
    else $error("answer without a request");
  property p_upper;
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper)
    else $error("read data wider than a byte");
  property p_hold;
    avs_waitrequest && !$past(sys_rst) |-> $stable(avs_readdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data changed between requests");
  property p_rst;
    disable iff (1'b0)
    sys_rst |=> avs_waitrequest && tc_event == 2'h0 && !port_line_zero_oe
      && !port_line_one_oe && avs_readdata == 32'h00000000;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  property p_oe0;
    port_line_zero_o |-> port_line_zero_oe;
  endproperty
  a_oe0: assert property (p_oe0)
    else $error("line 0 high while not driven");
  property p_oe1;
    port_line_one_o |-> port_line_one_oe;
  endproperty
  a_oe1: assert property (p_oe1)
    else $error("line 1 high while not driven");
  property p_evt;
    tc_event != 2'h0 |=> (tc_event & $past(tc_event)) == 2'h0;
  endproperty
  a_evt: assert property (p_evt)
    else $error("event pulse longer than one cycle");
endmodule
bind dual_timer_counter_unit tc_bus_check #(.GATE_CYCLES(GATE_CYCLES)) chk (
  .core_clk          (core_clk),
  .sys_rst           (sys_rst),
  .avs_read          (avs_read),
  .avs_write         (avs_write),
  .avs_readdata      (avs_readdata),
  .avs_waitrequest   (avs_waitrequest),
  .port_line_zero_o  (port_line_zero_o),
  .port_line_zero_oe (port_line_zero_oe),
  .port_line_one_o   (port_line_one_o),
  .port_line_one_oe  (port_line_one_oe),
  .tc_event          (tc_event)
);
`default_nettype wire

// *** dv/pulse_source.sv ***
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
  input  wire logic       core_clk, // clock
  output var  logic [3:0] line      // input lines 4..7
);
  logic [1:0] q_r; // encoder phase

  // lines rest low until a burst
  initial begin
    line = 4'h0;
    q_r  = 2'h0;
  end

  // n pulses on one line, half period hp cycles
  task automatic burst(input int ln, input int n, input int hp);
    repeat (2 * n) begin
      @(posedge core_clk);
      line[ln] <= ~line[ln];
      repeat (hp - 1) @(posedge core_clk);
    end
  endtask

  // gray steps on lines 4 and 5, only one bit moves per step
  task automatic quad(input int n, input logic up);
    repeat (n) begin
      @(posedge core_clk);
      q_r = up ? q_r + 2'h1 : q_r - 2'h1;
      line[1:0] <= {q_r[1], q_r[1] ^ q_r[0]};
      repeat (3) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// *** dv/dual_timer_counter_unit_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module dual_timer_counter_unit_tb;
  logic        core_clk;
  logic        sys_rst;
  logic [6:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  lines;
  logic        port_line_zero_o;
  logic        port_line_zero_oe;
  logic        port_line_one_o;
  logic        port_line_one_oe;
  logic [1:0]  tc_event;
  int          bad_count;
  int          checks_done;
  logic [7:0]  q;
  logic [15:0] v;
  int          w;

  dual_timer_counter_unit #(.GATE_CYCLES(50)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_line_four(lines[0]), .port_line_five(lines[1]),
    .port_line_six(lines[2]), .port_line_seven(lines[3]),
    .port_line_zero_o(port_line_zero_o),
    .port_line_zero_oe(port_line_zero_oe),
    .port_line_one_o(port_line_one_o), .port_line_one_oe(port_line_one_oe),
    .tc_event(tc_event));

  pulse_source src (.core_clk(core_clk), .line(lines));

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  // one byte access, held until the answer
  task automatic bus(input logic wr, input logic [4:0] idx,
                     input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata[7:0];
    if (n >= 50) bad_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rd(input logic [4:0] idx, output logic [7:0] r);
    bus(1'b0, idx, 8'h00, r);
  endtask
  // load low byte then high byte, high commits
  task automatic ld(input logic [4:0] b, input logic [15:0] d);
    wr(b + 5'h02, d[7:0]);
    wr(b + 5'h03, d[15:8]);
  endtask
  // latch low byte freezes high byte
  task automatic rd16(input logic [4:0] b, output logic [15:0] r);
    rd(b + 5'h04, r[7:0]);
    rd(b + 5'h05, r[15:8]);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // cycles that an output pin stays high
  task automatic hi_width(input int u, output int n);
    int k;
    k = 0;
    n = 0;
    while ((u ? port_line_one_o : port_line_zero_o) !== 1'b1 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    while ((u ? port_line_one_o : port_line_zero_o) === 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic rst;
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hung bus or pin
  initial begin
    #5000000;
    bad_count++;
    final_report;
  end

  // main sequence
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h1;
    avs_writedata = 32'h00000000;
    bad_count = 0;
    checks_done = 0;
    rst;
    rd(5'h00, q); chk(q, 8'h00);
    wr(5'h1f, 8'ha5); rd(5'h1f, q); chk(q, 8'h00);
    wr(5'h01, 8'h1b); rd(5'h01, q); chk(q, 8'h1b);
    rd(5'h09, q); chk(q, 8'h00);
    // total count on line 6, line 4 must not count
    wr(5'h01, 8'h10);
    for (int e = 0; e < 3; e++) begin
      wr(5'h00, {1'b0, e[1:0], 5'h14});
      ld(5'h00, 16'h0000);
      src.burst(0, 3, 4);
      src.burst(2, 5, 4);
      repeat (4) @(posedge core_clk);
      rd16(5'h00, v); chk(v, e == 2 ? 16'h000a : 16'h0005);
    end
    // quadrature on lines 4 and 5, unit zero alone
    rst;
    wr(5'h00, 8'h05);
    ld(5'h00, 16'h0000);
    src.quad(6, 1'b1);
    repeat (4) @(posedge core_clk);
    // line 4 leading line 5 counts downward
    rd16(5'h00, v); chk(v, 16'hfffa);
    src.quad(6, 1'b0);
    repeat (4) @(posedge core_clk);
    rd16(5'h00, v); chk(v, 16'h0000);
    // output functions after a fresh start
    rst;
    wr(5'h08, 8'h07);
    ld(5'h08, 16'h000a);
    hi_width(1, w); chk(16'(w >= 19 && w <= 21), 16'h0001);
    wr(5'h00, 8'h06);
    ld(5'h00, 16'h0003);
    hi_width(0, w);
    hi_width(0, w); chk(16'(w), 16'h0006);
    chk({15'h0000, port_line_zero_oe}, 16'h0001);
    // transition logging: unit zero high phases, unit one low
    rst;
    wr(5'h10, 8'h01); rd(5'h10, q); chk(q, 8'h01);
    src.burst(0, 2, 8);
    rd16(5'h00, v); chk(v, 16'h0004);
    rd16(5'h08, v); chk(v, 16'h0004);
    // edge divide by four on line 4, divisor loaded as two
    wr(5'h10, 8'h00);
    wr(5'h00, 8'h0a);
    ld(5'h00, 16'h0002);
    fork
      src.burst(0, 8, 4);
      begin
        hi_width(0, w); chk(16'(w), 16'h0010);
        hi_width(0, w); chk(16'(w), 16'h0010);
      end
    join
    // gated count, five rises in every fifty cycle gate
    rst;
    wr(5'h00, 8'h03);
    fork
      src.burst(0, 20, 5);
      begin
        repeat (120) @(posedge core_clk);
        rd16(5'h00, v); chk(v, 16'h0005);
      end
    join
    // triggered count, pulse ends at third rise on line 5
    wr(5'h01, 8'h08);
    wr(5'h00, 8'h0b);
    ld(5'h00, 16'h0003);
    src.burst(1, 2, 4); chk({15'h0000, port_line_zero_o}, 16'h0001);
    src.burst(1, 1, 4); chk({15'h0000, port_line_zero_o}, 16'h0000);
    // three output pulses of two cycles, then silence
    wr(5'h08, 8'h08);
    ld(5'h08, 16'h0003);
    repeat (3) begin
      hi_width(1, w); chk(16'(w), 16'h0002);
    end
    hi_width(1, w); chk(16'(w), 16'h0000);
    // capture flag set by the event, cleared by its read
    rd(5'h0e, q); chk(q, 8'h01);
    rd(5'h0e, q); chk(q, 8'h00);
    // pulse width at full, half and zero duty
    rst;
    wr(5'h08, 8'h09);
    ld(5'h08, 16'h0100);
    repeat (4) @(posedge core_clk);
    chk({15'h0000, port_line_one_o}, 16'h0001);
    ld(5'h08, 16'h0080);
    hi_width(1, w);
    hi_width(1, w); chk(16'(w), 16'h0100);
    ld(5'h08, 16'h0000);
    repeat (4) @(posedge core_clk);
    chk({15'h0000, port_line_one_o}, 16'h0000);
    final_report;
  end
endmodule
`default_nettype wire
